/* File: design/ext_irq_pin_and_vectors.sv */
/*
  External interrupt pin logic, low-voltage warning source, priority
  arbitration over 32 vectors and the entry sequence toward the core.
  Assumes one 20 MHz clock, synchronous active-high reset, a classic
  Wishbone master, a program memory that returns fetch data in the
  same cycle as the fetch strobe, and peripherals that present their
  requests already gated by their local enables.
*/
`timescale 1ns/1ns
`default_nettype none

module ext_irq_pin_and_vectors
  import ext_irq_pkg::*;
(
  input  wire logic                    ref_clk,        // Bus clock
  input  wire logic                    sys_rst,        // Synchronous reset
  // Wishbone slave
  input  wire logic                    wb_cyc_i,       // Cycle
  input  wire logic                    wb_stb_i,       // Strobe
  input  wire logic                    wb_we_i,        // Write
  input  wire logic [7:0]              wb_adr_i,       // Byte address
  input  wire logic [3:0]              wb_sel_i,       // Byte lanes
  input  wire logic [31:0]             wb_dat_i,       // Write data
  output logic      [31:0]             wb_dat_o,       // Read data
  output logic                         wb_ack_o,       // Acknowledge
  // Pin
  input  wire logic                    extIntPin,      // Raw pin level
  output logic                         pullUpEnable,   // Internal pull-up on
  output logic                         pullDownEnable, // Internal pull-down on
  output logic                         stopWake,       // Asynchronous wake request
  output logic                         branchPinValid, // Pin level usable by branches
  output logic                         branchPinHigh,  // Pin level for branches
  // Low-voltage warning detector
  input  wire logic                    lowVoltWarn,    // Raw detector level
  // Sources and core
  input  wire logic [PERIPH_COUNT-1:0] periphReq,      // Vectors 4 to 31
  input  wire logic                    resetReq,       // Any reset cause
  input  wire logic                    swiReq,         // Software interrupt
  input  wire logic                    globalMask,     // Core mask bit
  input  wire logic                    instrDone,      // Core ends an instruction
  output logic                         cpuIrqReq,      // Qualified request
  output stack_item_t                  stackPush,      // Item to push this cycle
  output logic                         setGlobalMask,  // Set mask pulse
  output vec_fetch_t                   vecFetch,       // Vector byte fetch
  input  wire logic [7:0]              fetchData,      // Fetched byte
  output logic      [15:0]             isrAddr,        // Service routine address
  output logic                         isrAddrValid,   // One-cycle pulse
  output logic      [4:0]              activeVector,   // Vector being served
  output logic                         irq             // Level event interrupt
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE, ST_PCL, ST_PCH, ST_X, ST_A, ST_CCR, ST_MASK, ST_FETCH_HI, ST_FETCH_LO
  } entry_state_t;

  ext_int_cfg_t          cfg;          // Pin configuration
  logic                  pinFlag;      // Pin event flag
  logic [2:0]            pinSync;      // Pin synchroniser chain
  logic                  pinLevel;     // Agreed pin level
  logic                  pinAsserted;  // Level seen last cycle as asserted
  logic [2:0]            lvwSync;      // Warning synchroniser chain
  logic                  lvwLevel;     // Agreed warning level
  logic                  lvwIntEnable; // Warning interrupt enable
  logic                  lvwFlag;      // Warning flag
  logic [EVT_WIDTH-1:0]  evtStatus;    // Sticky events
  logic [EVT_WIDTH-1:0]  evtMask;      // Event mask
  entry_state_t          state;        // Entry sequence state
  logic [4:0]            latchedVec;   // Vector chosen for this entry
  logic [7:0]            hiByte;       // Fetched high byte

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wrLane0   = busReq & wb_we_i & wb_sel_i[0];
  wire       selCtrl   = (wb_adr_i == OFS_EXT_INT_CTRL_STATUS);
  wire       selPower  = (wb_adr_i == OFS_POWER_MGMT_CTRL_ONE);
  wire       selStatus = (wb_adr_i == OFS_EVENT_STATUS);
  wire       selMask   = (wb_adr_i == OFS_EVENT_MASK);
  wire       selPend   = (wb_adr_i == OFS_PENDING_VECTOR);
  wire       wrCtrl    = wrLane0 & selCtrl;
  wire       wrPower   = wrLane0 & selPower;
  wire       wrStatus  = wrLane0 & selStatus;
  wire       wrMask    = wrLane0 & selMask;
  wire [7:0] wrByte    = wb_dat_i[7:0];

  // ----------------------------------------------------------------
  // Pin detection
  // ----------------------------------------------------------------
  // Stages two and three must agree before the level moves
  wire pinStable  = (pinSync[1] == pinSync[2]);
  wire nextLevel  = pinStable ? pinSync[2] : pinLevel;
  wire assertedNow = cfg.pinEnable & (cfg.polarity ? nextLevel : ~nextLevel);
  wire pinEdge    = assertedNow & ~pinAsserted;
  wire pinHold    = cfg.levelMode & assertedNow;
  wire pinAck     = wrCtrl & wrByte[BIT_ACKNOWLEDGE];

  // ----------------------------------------------------------------
  // Warning detection
  // ----------------------------------------------------------------
  wire lvwStable = (lvwSync[1] == lvwSync[2]);
  wire nextLvw   = lvwStable ? lvwSync[2] : lvwLevel;
  wire lvwSet    = nextLvw & lvwIntEnable;
  wire lvwAck    = wrPower & wrByte[BIT_LVW_ACK];

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Lowest pending number wins; reset sits at zero so beats all
  function automatic logic [5:0] pick_vector(input logic [VEC_COUNT-1:0] pend);
    logic [5:0] res;
    res = 6'h00;
    for (int i = VEC_COUNT - 1; i >= 0; i--) begin
      if (pend[i]) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  wire [VEC_COUNT-1:0] pending = {periphReq,
                                  lvwFlag & lvwIntEnable,
                                  pinFlag & cfg.requestEnable,
                                  swiReq,
                                  resetReq};
  wire [5:0]  winner     = pick_vector(pending);
  wire        anyPending = winner[5];
  wire [4:0]  winVec     = winner[4:0];
  wire        maskable   = |pending[VEC_COUNT-1:1];
  // Entry starts on reset at once, otherwise only unmasked at an instruction end
  wire        startEntry = (state == ST_IDLE) & (resetReq | (maskable & ~globalMask & instrDone));
  // Entry for vector n begins at top minus two per step
  wire [15:0] vecHiAddr  = VEC_TOP_ADDR - {10'h000, latchedVec, 1'b0};
  wire [15:0] vecLoAddr  = vecHiAddr + 16'h0001;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] ctrlRead = {1'b0, cfg.pullDisable, cfg.polarity, cfg.pinEnable,
                         pinFlag, 1'b0, cfg.requestEnable, cfg.levelMode};
  wire [7:0] powerRead = {6'h00, lvwIntEnable, lvwFlag};
  wire [7:0] readByte  = selCtrl   ? ctrlRead :
                         selPower  ? powerRead :
                         selStatus ? {5'h00, evtStatus} :
                         selMask   ? {5'h00, evtMask} :
                         selPend   ? {2'h0, anyPending, winVec} :
                         8'h00;

  // ----------------------------------------------------------------
  // Combinational outputs
  // ----------------------------------------------------------------
  // Pull direction follows polarity; off when disabled or not enabled
  assign pullUpEnable   = cfg.pinEnable & ~cfg.pullDisable & ~cfg.polarity;
  assign pullDownEnable = cfg.pinEnable & ~cfg.pullDisable & cfg.polarity;
  // Raw pin straight through gates, so no clock is needed to wake
  assign stopWake       = cfg.pinEnable & (cfg.polarity ? extIntPin : ~extIntPin);
  assign branchPinValid = cfg.pinEnable;
  assign cpuIrqReq      = maskable & ~globalMask;
  assign irq            = |(evtStatus & evtMask);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Three stages for each asynchronous input
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinSync <= 3'h0;
      lvwSync <= 3'h0;
    end else begin
      pinSync <= {pinSync[1:0], extIntPin};
      lvwSync <= {lvwSync[1:0], lowVoltWarn};
    end
  end

  // ----------------------------------------------------------------
  // Pin state and flag
  // ----------------------------------------------------------------
  // Agreed level, last asserted state and branch copy
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinLevel      <= 1'b0;
      pinAsserted   <= 1'b0;
      branchPinHigh <= 1'b0;
    end else begin
      pinLevel      <= nextLevel;
      pinAsserted   <= assertedNow;
      branchPinHigh <= cfg.pinEnable & nextLevel;
    end
  end

  // Flag: edge or held level sets, acknowledge clears, set wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinFlag <= 1'b0;
    end else if (pinEdge | pinHold) begin
      pinFlag <= 1'b1;
    end else if (pinAck) begin
      pinFlag <= 1'b0;
    end
  end

  // Control fields written from lane zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg <= '0;
    end else if (wrCtrl) begin
      cfg.pullDisable   <= wrByte[BIT_PULL_DISABLE];
      cfg.polarity      <= wrByte[BIT_POLARITY];
      cfg.pinEnable     <= wrByte[BIT_PIN_ENABLE];
      cfg.requestEnable <= wrByte[BIT_REQUEST_ENABLE];
      cfg.levelMode     <= wrByte[BIT_LEVEL_MODE];
    end
  end

  // ----------------------------------------------------------------
  // Low-voltage warning
  // ----------------------------------------------------------------
  // Enable, agreed level and flag with set winning over acknowledge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lvwIntEnable <= 1'b0;
      lvwLevel     <= 1'b0;
      lvwFlag      <= 1'b0;
    end else begin
      lvwLevel <= nextLvw;
      if (wrPower) begin
        lvwIntEnable <= wrByte[BIT_LVW_INT_ENABLE];
      end
      if (lvwSet) begin
        lvwFlag <= 1'b1;
      end else if (lvwAck) begin
        lvwFlag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------
  wire [EVT_WIDTH-1:0] evtSet = {isrAddrValid, lvwSet & ~lvwFlag, (pinEdge | pinHold) & ~pinFlag};
  wire [EVT_WIDTH-1:0] evtClr = wrStatus ? wrByte[EVT_WIDTH-1:0] : '0;

  // Sticky bits: set wins over a write-one clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      evtStatus <= '0;
      evtMask   <= RST_EVENT_MASK;
    end else begin
      evtStatus <= evtSet | (evtStatus & ~evtClr);
      if (wrMask) begin
        evtMask <= wrByte[EVT_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq & ~wb_we_i) begin
        wb_dat_o <= {24'h000000, readByte};      // Unmapped reads give zero
      end
    end
  end

  // ----------------------------------------------------------------
  // Entry sequence
  // ----------------------------------------------------------------
  // Push order, mask set, then two vector byte fetches
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state        <= ST_IDLE;
      stackPush    <= STK_NONE;
      setGlobalMask <= 1'b0;
      vecFetch     <= '0;
      latchedVec   <= VEC_RESET;
      hiByte       <= 8'h00;
      isrAddr      <= 16'h0000;
      isrAddrValid <= 1'b0;
      activeVector <= VEC_RESET;
    end else begin
      stackPush     <= STK_NONE;
      setGlobalMask <= 1'b0;
      vecFetch      <= '0;
      isrAddrValid  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (startEntry & resetReq) begin
            latchedVec <= VEC_RESET;             // No stacking on reset
            state      <= ST_MASK;
          end else if (startEntry) begin
            stackPush  <= STK_PCL;
            state      <= ST_PCL;
          end
        end
        ST_PCL: begin
          stackPush <= STK_PCH;
          state     <= ST_PCH;
        end
        ST_PCH: begin
          stackPush <= STK_X;
          state     <= ST_X;
        end
        ST_X: begin
          stackPush <= STK_A;
          state     <= ST_A;
        end
        ST_A: begin
          stackPush <= STK_CCR;
          state     <= ST_CCR;
        end
        ST_CCR: begin
          state <= ST_MASK;
        end
        ST_MASK: begin
          // Winner chosen after stacking, as late as possible
          setGlobalMask <= 1'b1;
          latchedVec    <= resetReq ? VEC_RESET : winVec;
          state         <= ST_FETCH_HI;
        end
        ST_FETCH_HI: begin
          vecFetch <= '{strobe: 1'b1, addr: vecHiAddr};
          state    <= ST_FETCH_LO;
        end
        ST_FETCH_LO: begin
          hiByte   <= fetchData;
          vecFetch <= '{strobe: 1'b1, addr: vecLoAddr};
          state    <= ST_IDLE;
          activeVector <= latchedVec;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (state == ST_IDLE && vecFetch.strobe) begin
        isrAddr      <= {hiByte, fetchData};
        isrAddrValid <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: design/ext_irq_pkg.sv */
/*
  Package for the external interrupt pin and vector dispatch block.
  Holds register offsets, field positions, reset values, vector table
  constants and the carrier types that the block and its bench share.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
package ext_irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_EXT_INT_CTRL_STATUS = 8'h00; // Pin control and flag
  localparam logic [7:0] OFS_POWER_MGMT_CTRL_ONE = 8'h04; // Low-voltage warning bits
  localparam logic [7:0] OFS_EVENT_STATUS        = 8'h08; // Sticky events, write 1 clears
  localparam logic [7:0] OFS_EVENT_MASK          = 8'h0C; // Event interrupt mask
  localparam logic [7:0] OFS_PENDING_VECTOR      = 8'h10; // Winning vector, read only

  // ----------------------------------------------------------------
  // Pin control and status fields
  // ----------------------------------------------------------------
  localparam int BIT_PULL_DISABLE   = 6;
  localparam int BIT_POLARITY       = 5;
  localparam int BIT_PIN_ENABLE     = 4;
  localparam int BIT_EVENT_FLAG     = 3;
  localparam int BIT_ACKNOWLEDGE    = 2;
  localparam int BIT_REQUEST_ENABLE = 1;
  localparam int BIT_LEVEL_MODE     = 0;

  // Low-voltage warning fields
  localparam int BIT_LVW_FLAG       = 0;
  localparam int BIT_LVW_INT_ENABLE = 1;
  localparam int BIT_LVW_ACK        = 2;

  // Sticky event bits
  localparam int EVT_PIN      = 0;
  localparam int EVT_LVW      = 1;
  localparam int EVT_DISPATCH = 2;
  localparam int EVT_WIDTH    = 3;

  // Pending vector readback fields
  localparam int BIT_PEND_VALID = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [EVT_WIDTH-1:0] RST_EVENT_MASK = 3'h0;

  // ----------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------
  localparam int              VEC_COUNT     = 32;
  localparam logic [15:0]     VEC_TOP_ADDR  = 16'hFFFE; // Reset entry, high byte
  localparam logic [4:0]      VEC_RESET     = 5'h00;
  localparam logic [4:0]      VEC_SWI       = 5'h01;
  localparam logic [4:0]      VEC_PIN       = 5'h02;
  localparam logic [4:0]      VEC_LVW       = 5'h03;
  localparam int              VEC_FIRST_EXT = 4;        // First peripheral vector
  localparam int              PERIPH_COUNT  = VEC_COUNT - VEC_FIRST_EXT;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Pin configuration as software left it
  typedef struct packed {
    logic pullDisable;
    logic polarity;
    logic pinEnable;
    logic requestEnable;
    logic levelMode;
  } ext_int_cfg_t;

  // Item the core must push during entry
  typedef enum logic [2:0] {
    STK_NONE, STK_PCL, STK_PCH, STK_X, STK_A, STK_CCR
  } stack_item_t;

  // Vector fetch request to program memory
  typedef struct packed {
    logic        strobe;
    logic [15:0] addr;
  } vec_fetch_t;

endpackage

/* File: dv/ext_irq_pin_and_vectors_chk.sv */
/*
  Checker for the interrupt pin and vector block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module ext_irq_pin_and_vectors_chk
  import ext_irq_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        wb_ack_o,
  input wire logic        pullUpEnable,
  input wire logic        pullDownEnable,
  input wire logic        stopWake,
  input wire logic        branchPinValid,
  input wire logic        globalMask,
  input wire logic        cpuIrqReq,
  input wire stack_item_t stackPush,
  input wire logic        setGlobalMask,
  input wire vec_fetch_t  vecFetch,
  input wire logic [7:0]  fetchData,
  input wire logic [15:0] isrAddr,
  input wire logic        isrAddrValid,
  input wire logic [4:0]  activeVector
);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_pull; !(pullUpEnable && pullDownEnable); endproperty
  a_pull: assert property (p_pull) else $error("both pulls on");
  property p_pullen; (pullUpEnable || pullDownEnable || stopWake) |-> branchPinValid; endproperty
  a_pullen: assert property (p_pullen) else $error("pin acts while off");
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_stack;
    stackPush == STK_PCL |=> stackPush == STK_PCH ##1 stackPush == STK_X
      ##1 stackPush == STK_A ##1 stackPush == STK_CCR;
  endproperty
  a_stack: assert property (p_stack) else $error("stacking order wrong");
  property p_mask; stackPush == STK_CCR |-> ##2 setGlobalMask ##1 vecFetch.strobe; endproperty
  a_mask: assert property (p_mask) else $error("mask not set after stacking");
  property p_lo;
    setGlobalMask |=> vecFetch.strobe ##1
      (vecFetch.strobe && vecFetch.addr == $past(vecFetch.addr) + 16'h1);
  endproperty
  a_lo: assert property (p_lo) else $error("low byte not at next address");
  property p_vaddr;
    isrAddrValid |-> $past(vecFetch.addr, 2) == VEC_TOP_ADDR - {10'h0, activeVector, 1'h0};
  endproperty
  a_vaddr: assert property (p_vaddr) else $error("vector address wrong");
  property p_isr; isrAddrValid |-> isrAddr == {$past(fetchData, 2), $past(fetchData)}; endproperty
  a_isr: assert property (p_isr) else $error("service address wrong");
  property p_req; cpuIrqReq |-> !globalMask; endproperty
  a_req: assert property (p_req) else $error("request while masked");
endmodule
`default_nettype wire

/* File: dv/cpu_core_model.sv */
/*
  Core model: ends an instruction every other cycle, keeps the
  global mask and serves vector bytes in the fetch cycle.
  Assumes the bench clears the mask through clrMask.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model
  import ext_irq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       setGlobalMask,
  input  wire vec_fetch_t vecFetch,
  input  wire logic       clrMask,
  output logic            globalMask,
  output logic            instrDone,
  output logic [7:0]      fetchData
);
  // Memory byte is the inverted low address byte
  assign fetchData = ~vecFetch.addr[7:0];
  // Mask and instruction pacing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      globalMask <= 1'h0;
      instrDone  <= 1'h0;
    end else begin
      instrDone <= ~instrDone;
      if (setGlobalMask) globalMask <= 1'h1;
      else if (clrMask) globalMask <= 1'h0;
    end
  end
endmodule
`default_nettype wire

/* File: dv/ext_irq_pin_and_vectors_tb.sv */
/*
  Self-checking bench for the interrupt pin and vector block.
  Assumes the core model answers vector fetches in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin nMismatch++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module ext_irq_pin_and_vectors_tb
  import ext_irq_pkg::*;
;
  logic ref_clk = 0, sysRst = 1, cyc = 0, stb = 0, we = 0, pin = 0, warn = 0;
  logic resetReq = 0, swiReq = 0, clrMask = 0, globalMask, instrDone, setGm;
  logic [7:0] adr = 8'h00, rdv, fetchData, q;
  logic [31:0] datO, datI = 32'h0;
  logic [PERIPH_COUNT-1:0] periphReq = '0;
  logic ack, pu, pd, wake, bpv, bph, cpuReq, isrV, irq;
  logic [15:0] isrAddr;
  logic [4:0] actV;
  stack_item_t push;
  vec_fetch_t vf;
  int nMismatch = 0, comparisons = 0;
  always #25 ref_clk = ~ref_clk;
  ext_irq_pin_and_vectors u_ext_irq_pin_and_vectors (.ref_clk(ref_clk), .sys_rst(sysRst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .extIntPin(pin), .pullUpEnable(pu),
    .pullDownEnable(pd), .stopWake(wake), .branchPinValid(bpv), .branchPinHigh(bph),
    .lowVoltWarn(warn), .periphReq(periphReq), .resetReq(resetReq), .swiReq(swiReq),
    .globalMask(globalMask), .instrDone(instrDone), .cpuIrqReq(cpuReq), .stackPush(push),
    .setGlobalMask(setGm), .vecFetch(vf), .fetchData(fetchData), .isrAddr(isrAddr),
    .isrAddrValid(isrV), .activeVector(actV), .irq(irq));
  cpu_core_model u_cpu_core_model (.ref_clk(ref_clk), .sys_rst(sysRst), .setGlobalMask(setGm),
    .vecFetch(vf), .clrMask(clrMask), .globalMask(globalMask), .instrDone(instrDone),
    .fetchData(fetchData));
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; datI <= {24'h0, d};
    n = 0;
    do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 20);
    // A bus answer that never comes counts as a mismatch
    if (ack !== 1'b1) nMismatch++;
    rdv = datO[7:0];
    cyc <= 0; stb <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'h0, a, 8'h00);
    `CHK("reg", e, rdv)
  endtask
  // Wait for a delivered service address, then check it
  task automatic entry(input logic [4:0] v, input logic [15:0] e);
    int n;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (isrV !== 1'b1 && n < 40);
    // A service address that never arrives counts as a mismatch
    if (isrV !== 1'b1) nMismatch++;
    `CHK("vector", v, actV)
    `CHK("isr", e, isrAddr)
  endtask
  task automatic t_reset;
    rd(OFS_EXT_INT_CTRL_STATUS, 8'h00);
    rd(8'h40, 8'h00);
    pin <= 1; repeat (6) @(posedge ref_clk); pin <= 0; repeat (6) @(posedge ref_clk);
    rd(OFS_EXT_INT_CTRL_STATUS, 8'h00);
    `CHK("pulls", 2'h0, {pu, pd})
  endtask
  task automatic t_pin;
    wb(1, OFS_EXT_INT_CTRL_STATUS, 8'h72);
    `CHK("pulloff", 2'h0, {pu, pd})
    wb(1, OFS_EXT_INT_CTRL_STATUS, 8'h32);
    `CHK("pulldown", 2'h1, {pu, pd})
    wb(1, OFS_EVENT_MASK, 8'h01);
    pin <= 1; repeat (6) @(posedge ref_clk);
    `CHK("bph", 2'h3, {bpv, bph})
    `CHK("irq", 1'h1, irq)
    entry(5'h02, 16'h0504);
    rd(OFS_EXT_INT_CTRL_STATUS, 8'h3A);
    `CHK("req", 1'h0, cpuReq)
    wb(1, OFS_EXT_INT_CTRL_STATUS, 8'h36);
    rd(OFS_EXT_INT_CTRL_STATUS, 8'h32);
    wb(1, OFS_EVENT_STATUS, 8'h01);
    `CHK("irqclr", 1'h0, irq)
  endtask
  task automatic t_level;
    pin <= 0; repeat (6) @(posedge ref_clk);
    wb(1, OFS_EXT_INT_CTRL_STATUS, 8'h33);
    pin <= 1; repeat (6) @(posedge ref_clk);
    wb(1, OFS_EXT_INT_CTRL_STATUS, 8'h37);
    rd(OFS_EXT_INT_CTRL_STATUS, 8'h3B);
    pin <= 0; repeat (6) @(posedge ref_clk);
    wb(1, OFS_EXT_INT_CTRL_STATUS, 8'h37);
    rd(OFS_EXT_INT_CTRL_STATUS, 8'h33);
    wb(1, OFS_EXT_INT_CTRL_STATUS, 8'h11);
    `CHK("pullup", 3'h5, {pu, pd, wake})
    wb(1, OFS_EXT_INT_CTRL_STATUS, 8'h00);
  endtask
  task automatic t_prio;
    periphReq <= 28'h8000001; swiReq <= 1;
    rd(OFS_PENDING_VECTOR, 8'h21);
    swiReq <= 0;
    rd(OFS_PENDING_VECTOR, 8'h24);
    resetReq <= 1;
    entry(5'h00, 16'h0100);
    // Reset is still seen high at the next idle edge, so one more reset entry follows
    resetReq <= 0;
    entry(5'h00, 16'h0100);
    // One-cycle mask clear, so only a single maskable entry is taken
    clrMask <= 1;
    @(posedge ref_clk);
    clrMask <= 0;
    entry(5'h04, 16'h0908);
    periphReq <= '0;
  endtask
  task automatic t_lvw;
    wb(1, OFS_POWER_MGMT_CTRL_ONE, 8'h02);
    warn <= 1; repeat (6) @(posedge ref_clk);
    rd(OFS_POWER_MGMT_CTRL_ONE, 8'h03);
    rd(OFS_PENDING_VECTOR, 8'h23);
    warn <= 0; repeat (6) @(posedge ref_clk);
    wb(1, OFS_POWER_MGMT_CTRL_ONE, 8'h06);
    rd(OFS_POWER_MGMT_CTRL_ONE, 8'h02);
  endtask
  // Verdict and end of run
  task automatic test_done;
    if (nMismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    sysRst <= 0;
    t_reset; t_pin; t_level; t_prio; t_lvw;
    test_done;
  end
  // Watchdog well beyond the expected run
  initial begin
    #(50 * 5000);
    nMismatch++;
    test_done;
  end
endmodule
bind ext_irq_pin_and_vectors ext_irq_pin_and_vectors_chk u_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .wb_ack_o(wb_ack_o), .pullUpEnable(pullUpEnable),
  .pullDownEnable(pullDownEnable), .stopWake(stopWake), .branchPinValid(branchPinValid),
  .globalMask(globalMask), .cpuIrqReq(cpuIrqReq), .stackPush(stackPush),
  .setGlobalMask(setGlobalMask), .vecFetch(vecFetch), .fetchData(fetchData),
  .isrAddr(isrAddr), .isrAddrValid(isrAddrValid), .activeVector(activeVector));
`default_nettype wire
